// ==== src/nps_defs.svh ====
// Operation
// - phase held in a 28-bit accumulator that wraps modulo two to the 28.
// - increment taken from frequency_word_a or frequency_word_b by pin or bit.
// - switching frequency words changes only the increment, phase stays continuous.
// - one of two 12-bit phase offsets added to the accumulator upper bits.
// - phase truncated to its upper 12 bits before waveform conversion.
// - sine table addressed by the truncated phase returns the amplitude sample.
// - samples are 10-bit codes; phase resolution is two bits wider.
// - sine table use set by digital_output_enable together with waveform mode bit.
// - comparator path enabled only when sign_output_source and output enable both set.
// - frequency selector follows pin or bit; unused pin held at a fixed level.
// - phase selector follows pin or bit; unused pin held at a fixed level.
// - active-high reset zeroes the accumulator and forces the stage code to midscale, giving midscale output.
`ifndef NPS_DEFS_SVH
`define NPS_DEFS_SVH
`define NPS_ACC_W     28
`define NPS_PHASE_W   12
`define NPS_AMP_W     10
`define NPS_ACC_ZERO  28'h0000000
`define NPS_AMP_MID   10'h200
`define NPS_SYNC_ZERO 3'h0
`endif

// ==== src/nps_pkg.sv ====
`include "nps_defs.svh"
package nps_pkg;
	typedef logic [`NPS_ACC_W-1:0]   nps_freq_t;
	typedef logic [`NPS_PHASE_W-1:0] nps_phase_t;
	typedef logic [`NPS_AMP_W-1:0]   nps_amp_t;
	typedef struct packed {
		nps_amp_t dacCode;
		logic     phaseMsb;
	} nps_sample_s;
	typedef enum logic [1:0] {
		NPS_EMPTY = 2'b01,
		NPS_FULL  = 2'b10
	} nps_buf_e;
endpackage

// ==== src/nps_sine_rom.sv ====
`timescale 1ns/1ps
`include "nps_defs.svh"
module nps_sine_rom (
	// clock
	input  wire logic               clk,
	// lookup
	input  wire nps_pkg::nps_phase_t phase,
	output nps_pkg::nps_amp_t        amp
);
	localparam int N = 1 << `NPS_PHASE_W;
	nps_pkg::nps_amp_t table_q [0:N-1];
	// table built at elaboration from a truncated sine, offset binary around midscale
	initial begin
		for (int i = 0; i < N; i++) begin
			table_q[i] = nps_pkg::nps_amp_t'($rtoi(511.5 + 511.5 *
				$sin(6.283185307179586 * i / N)));
		end
	end
	always_ff @(posedge clk) begin
		amp <= table_q[phase];
	end
endmodule

// ==== src/nps_skid_buffer.sv ====
`timescale 1ns/1ps
module nps_skid_buffer #(
	parameter int WIDTH = 11
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// fill side
	input  wire logic [WIDTH-1:0] inData,
	input  wire logic             inValid,
	output logic                  inReady,
	// drain side
	output logic [WIDTH-1:0]      outData,
	output logic                  outValid,
	input  wire logic             outReady
);
	logic [WIDTH-1:0] mem_reg [0:1];
	logic             wrPtr_reg;
	logic             rdPtr_reg;
	logic [1:0]       count_reg;
	wire              doWr = inValid && inReady;
	wire              doRd = outValid && outReady;
	assign inReady  = count_reg != 2'h2;
	assign outValid = count_reg != 2'h0;
	assign outData  = mem_reg[rdPtr_reg];
	always_ff @(posedge clk) begin
		if (doWr) begin
			mem_reg[wrPtr_reg] <= inData;
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wrPtr_reg <= 1'b0;
			rdPtr_reg <= 1'b0;
			count_reg <= 2'h0;
		end else begin
			wrPtr_reg <= wrPtr_reg ^ doWr;
			rdPtr_reg <= rdPtr_reg ^ doRd;
			count_reg <= count_reg + {1'b0, doWr} - {1'b0, doRd};
		end
	end
endmodule

// ==== src/nps_nco.sv ====
`timescale 1ns/1ps
`include "nps_defs.svh"
module nps_nco (
	// clock and resets
	input  wire logic                clk,
	input  wire logic                rst_n,
	input  wire logic                accReset,
	// tuning words
	input  wire nps_pkg::nps_freq_t  frequency_word_a,
	input  wire nps_pkg::nps_freq_t  frequency_word_b,
	input  wire nps_pkg::nps_phase_t phase_offset_a,
	input  wire nps_pkg::nps_phase_t phase_offset_b,
	// selectors
	input  wire logic                freq_select_pin,
	input  wire logic                freq_select_bit,
	input  wire logic                phase_select_pin,
	input  wire logic                phase_select_bit,
	input  wire logic                selectFromPins,
	// control
	input  wire logic                digital_output_enable,
	input  wire logic                waveModeTriangle,
	input  wire logic                sign_output_source,
	input  wire logic                comparatorIn,
	// sample stream
	input  wire logic                sinkReady,
	output logic                     sampleValid,
	output nps_pkg::nps_amp_t        dacCode,
	output logic                     square_wave_output_pin,
	output logic                     squareEnable
);
	// three-stage synchronisers for pins from outside the clock domain
	logic [2:0] fSync_reg;
	logic [2:0] pSync_reg;
	logic [2:0] cSync_reg;
	logic       freq_select_bit_reg;
	logic       pSel_reg;
	logic       cmp_reg;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fSync_reg <= `NPS_SYNC_ZERO;
			pSync_reg <= `NPS_SYNC_ZERO;
			cSync_reg <= `NPS_SYNC_ZERO;
			freq_select_bit_reg  <= 1'b0;
			pSel_reg  <= 1'b0;
			cmp_reg   <= 1'b0;
		end else begin
			fSync_reg <= {fSync_reg[1:0], freq_select_pin};
			pSync_reg <= {pSync_reg[1:0], phase_select_pin};
			cSync_reg <= {cSync_reg[1:0], comparatorIn};
			if (fSync_reg[1] == fSync_reg[2]) begin
				freq_select_bit_reg <= fSync_reg[2];
			end
			if (pSync_reg[1] == pSync_reg[2]) begin
				pSel_reg <= pSync_reg[2];
			end
			if (cSync_reg[1] == cSync_reg[2]) begin
				cmp_reg <= cSync_reg[2];
			end
		end
	end

	wire useB      = selectFromPins ? freq_select_bit_reg : freq_select_bit;
	wire usePhaseB = selectFromPins ? pSel_reg : phase_select_bit;
	wire nps_pkg::nps_freq_t  step   = useB ? frequency_word_b : frequency_word_a;
	wire nps_pkg::nps_phase_t offset = usePhaseB ? phase_offset_b : phase_offset_a;

	nps_pkg::nps_freq_t  acc_reg;
	nps_pkg::nps_freq_t  acc_next;
	nps_pkg::nps_phase_t phase_reg;
	logic                hold;
	// a full buffer holds the accumulator so no phase step is lost
	assign acc_next = acc_reg + step;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_reg <= `NPS_ACC_ZERO;
		end else if (accReset) begin
			acc_reg <= `NPS_ACC_ZERO;
		end else if (!hold) begin
			acc_reg <= acc_next;
		end
	end
	// truncate to the top bits, then offset in units of a 4096th of a cycle
	wire nps_pkg::nps_phase_t truncPhase =
		acc_reg[`NPS_ACC_W-1 -: `NPS_PHASE_W];
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_reg <= '0;
		end else if (!hold) begin
			phase_reg <= truncPhase + offset;
		end
	end

	// the table address holds too, else a stall pairs a new code with an old phase msb
	nps_pkg::nps_amp_t   romAmp;
	nps_pkg::nps_phase_t romPhase_reg;
	logic                romValid_reg;
	wire nps_pkg::nps_phase_t romAddr = hold ? romPhase_reg : phase_reg;
	nps_sine_rom u_rom (
		.clk   (clk),
		.phase (romAddr),
		.amp   (romAmp)
	);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			romPhase_reg <= '0;
			romValid_reg <= 1'b0;
		end else if (!hold) begin
			romPhase_reg <= phase_reg;
			romValid_reg <= !accReset;
		end
	end

	// triangle folds the phase instead of using the table
	wire       sineUsed = !digital_output_enable && !waveModeTriangle;
	wire [`NPS_PHASE_W-2:0] fold = phase_reg[`NPS_PHASE_W-1] ?
		~phase_reg[`NPS_PHASE_W-2:0] : phase_reg[`NPS_PHASE_W-2:0];
	nps_pkg::nps_amp_t triAmp_reg;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			triAmp_reg <= `NPS_AMP_MID;
		end else if (!hold) begin
			triAmp_reg <= fold[`NPS_PHASE_W-2 -: `NPS_AMP_W];
		end
	end
	nps_pkg::nps_sample_s stage;
	wire nps_pkg::nps_amp_t stageCode = accReset ? `NPS_AMP_MID :
		(sineUsed ? romAmp : triAmp_reg);
	assign stage = {stageCode, romPhase_reg[`NPS_PHASE_W-1]};

	logic                 inReady;
	logic                 bufValid;
	nps_pkg::nps_sample_s bufOut;
	assign hold = !inReady;
	nps_skid_buffer #(.WIDTH($bits(nps_pkg::nps_sample_s))) u_buf (
		.clk      (clk),
		.rst_n    (rst_n),
		.inData   (stage),
		.inValid  (romValid_reg),
		.inReady  (inReady),
		.outData  (bufOut),
		.outValid (bufValid),
		.outReady (sinkReady)
	);

	wire cmpPath = sign_output_source && digital_output_enable;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sampleValid            <= 1'b0;
			dacCode                <= `NPS_AMP_MID;
			square_wave_output_pin <= 1'b0;
			squareEnable           <= 1'b0;
		end else begin
			sampleValid            <= bufValid && sinkReady;
			if (bufValid && sinkReady) begin
				dacCode <= bufOut.dacCode;
			end
			square_wave_output_pin <= digital_output_enable &&
				(cmpPath ? cmp_reg : bufOut.phaseMsb);
			squareEnable           <= digital_output_enable;
		end
	end
endmodule

// ==== test/nps_nco_checker.sv ====
`timescale 1ns/1ps
module nps_nco_checker (
	// clock and resets
	input wire logic              clk,
	input wire logic              rst_n,
	input wire logic              accReset,
	// control and stream
	input wire logic              digital_output_enable,
	input wire logic              sign_output_source,
	input wire logic              comparatorIn,
	input wire logic              sinkReady,
	input wire logic              sampleValid,
	input wire nps_pkg::nps_amp_t dacCode,
	input wire logic              square_wave_output_pin
);
	logic [3:0] rstCnt_reg;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ready cycles under accumulator reset; six flush buffer and stage, saturates
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rstCnt_reg <= 4'h0;
		end else if (!accReset) begin
			rstCnt_reg <= 4'h0;
		end else if (sinkReady && rstCnt_reg != 4'hF) begin
			rstCnt_reg <= rstCnt_reg + 4'h1;
		end
	end
	a_acc_mid: assert property (rstCnt_reg > 4'h5 |-> dacCode == 10'h200)
		else $error("code not midscale under accumulator reset");
	a_rst_out: assert property ($rose(rst_n) |-> dacCode == 10'h200 && !sampleValid)
		else $error("outputs wrong after reset");
	a_code_hold: assert property ($changed(dacCode) |-> sampleValid)
		else $error("code moved without a sample");
	a_cmp_path: assert property ((digital_output_enable && sign_output_source
		&& $stable(comparatorIn))[*6] |=> square_wave_output_pin == $past(comparatorIn))
		else $error("comparator not on square pin");
	a_sq_off: assert property ((!digital_output_enable)[*2] |=> !square_wave_output_pin)
		else $error("square pin driven while disabled");
	a_stall_quiet: assert property ((!sinkReady)[*3] |=> !sampleValid)
		else $error("sample sent during stall");
	a_flow_run: assert property ((sinkReady && !accReset)[*8] |=> sampleValid)
		else $error("stream stopped while ready");
	a_sq_reset: assert property (!digital_output_enable ##1 !digital_output_enable
		|-> ##1 !square_wave_output_pin ##1 1'b1)
		else $error("square pin not low");
endmodule
bind nps_nco nps_nco_checker nps_nco_checker_inst (.clk(clk), .rst_n(rst_n),
	.accReset(accReset), .digital_output_enable(digital_output_enable),
	.sign_output_source(sign_output_source), .comparatorIn(comparatorIn),
	.sinkReady(sinkReady), .sampleValid(sampleValid), .dacCode(dacCode),
	.square_wave_output_pin(square_wave_output_pin));

// ==== test/nps_dac_sink.sv ====
`timescale 1ns/1ps
module nps_dac_sink (
	// clock
	input wire logic              clk,
	// 0 ready, 1 random stalls, 2 full stall
	input wire logic [1:0]        mode,
	// stream
	input wire logic              sampleValid,
	input wire nps_pkg::nps_amp_t dacCode,
	output logic                  sinkReady
);
	int taken = 0;
	always @(negedge clk) begin
		sinkReady <= (mode == 2'h0) ? 1'b1 : (mode == 2'h1) ? 1'($urandom) : 1'b0;
	end
	// sampleValid already marks an accepted word, so ready is not required again
	always @(negedge clk) begin
		if (sampleValid)
			taken++;
	end
endmodule

// ==== test/tb.sv ====
`timescale 1ns/1ps
`define CHK(a, e) begin totalChecks++; if ((a) !== (e)) begin miscompares++; $display("[FAIL] t=%0t got=%h exp=%h", $time, a, e); end end
module tb;
	logic clk, rst_n, accReset, fsPin, fsBit, psPin, psBit, fromPins;
	logic outEn, triMode, signSrc, cmpIn, sinkReady, sampleValid, sq, sqEn, prev;
	logic [1:0] sinkMode;
	nps_pkg::nps_freq_t fwA, fwB;
	nps_pkg::nps_phase_t poA, poB;
	nps_pkg::nps_amp_t dac;
	int miscompares = 0, totalChecks = 0, cyc = 0, n;
	int expCode;
	bit modelOn = 1'b0;
	nps_nco nps_nco_inst (.clk(clk), .rst_n(rst_n), .accReset(accReset),
		.frequency_word_a(fwA), .frequency_word_b(fwB), .phase_offset_a(poA),
		.phase_offset_b(poB), .freq_select_pin(fsPin), .freq_select_bit(fsBit),
		.phase_select_pin(psPin), .phase_select_bit(psBit), .selectFromPins(fromPins),
		.digital_output_enable(outEn), .waveModeTriangle(triMode), .sign_output_source(signSrc),
		.comparatorIn(cmpIn), .sinkReady(sinkReady), .sampleValid(sampleValid),
		.dacCode(dac), .square_wave_output_pin(sq), .squareEnable(sqEn));
	nps_dac_sink nps_dac_sink_inst (.clk(clk), .mode(sinkMode), .sampleValid(sampleValid),
		.dacCode(dac), .sinkReady(sinkReady));
	task automatic tick(input int k);
		repeat (k) @(negedge clk);
	endtask
	// model: accumulator frozen at zero, so each word is the sine of the offset
	always @(negedge clk) begin
		if (modelOn && sampleValid) begin
			expCode = $rtoi(511.5 + 511.5 * $sin(6.283185307179586 * poB / 4096.0));
			`CHK(dac inside {[expCode - 1:expCode + 1]}, 1'b1)
		end
	end
	task closeOut;
		$display("checks=%0d miscompares=%0d", totalChecks, miscompares);
		if (miscompares == 0 && totalChecks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 6000) begin
			miscompares++;
			closeOut();
		end
	end
	initial begin
		{rst_n, fsPin, fsBit, psPin, psBit, fromPins, triMode, signSrc, cmpIn} = '0;
		accReset = 1'b1;
		outEn = 1'b1;
		sinkMode = 2'h0;
		// half-cycle step: msb flips every sample, wrap included
		fwA = 28'h8000000;
		fwB = 28'h0000000;
		poA = 12'h000;
		poB = 12'h800;
		void'($urandom(32'h03AA8F1C));
		tick(12);
		rst_n = 1'b1;
		tick(12);
		`CHK(dac, 10'h200)
		accReset = 1'b0;
		tick(10);
		prev = sq;
		tick(1);
		`CHK(sq, ~prev)
		fsBit = 1'b1;
		tick(10);
		prev = sq;
		tick(3);
		`CHK(sq, prev)
		psBit = 1'b1;
		tick(10);
		`CHK(sq, ~prev)
		fromPins = 1'b1;
		tick(10);
		prev = sq;
		tick(1);
		`CHK(sq, ~prev)
		fsPin = 1'b1;
		tick(10);
		prev = sq;
		tick(2);
		`CHK(sq, prev)
		psPin = 1'b1;
		tick(10);
		`CHK(sq, ~prev)
		outEn = 1'b0;
		accReset = 1'b1;
		tick(8);
		`CHK(dac, 10'h200)
		accReset = 1'b0;
		`CHK(sq, 1'b0)
		`CHK(sqEn, 1'b0)
		repeat (6) begin
			poB = 12'h200 + 12'($urandom_range(1023, 0));
			tick(6);
			modelOn = 1'b1;
			tick(4);
			modelOn = 1'b0;
			`CHK(dac > 10'h200, 1'b1)
			poB ^= 12'h800;
			tick(6);
			modelOn = 1'b1;
			tick(4);
			modelOn = 1'b0;
			`CHK(dac < 10'h200, 1'b1)
		end
		triMode = 1'b1;
		poB = 12'($urandom_range(4095, 0));
		tick(10);
		`CHK(dac, 10'((poB < 12'h800) ? poB >> 1 : (12'hFFF - poB) >> 1))
		triMode = 1'b0;
		outEn = 1'b1;
		signSrc = 1'b1;
		sinkMode = 2'h1;
		repeat (6) begin
			cmpIn = 1'($urandom);
			tick(8);
			`CHK(sq, cmpIn)
		end
		`CHK(sqEn, 1'b1)
		sinkMode = 2'h2;
		tick(20);
		n = nps_dac_sink_inst.taken;
		sinkMode = 2'h0;
		tick(20);
		`CHK(nps_dac_sink_inst.taken - n > 12, 1'b1)
		closeOut();
	end
endmodule
